// [inc/fpvc_consts.vh]
`ifndef FPVC_CONSTS_VH
`define FPVC_CONSTS_VH
// ----------------------------------------
// extension register indices
// ----------------------------------------
`define FPVC_IDX_VCOMP 8'h57
`define FPVC_IDX_TOPLO 8'h58
`define FPVC_IDX_INSERT 8'h59
`define FPVC_IDX_REPL 8'h5A
`define FPVC_IDX_PWRDLY 8'h5B
`define FPVC_IDX_STATUS 8'h5C
`define FPVC_IDX_ACDRV 8'h5E
`define FPVC_IDX_BLINK 8'h60
`define FPVC_IDX_SEPCTL 8'h61
`define FPVC_IDX_SHIFT 8'h62
`define FPVC_IDX_MONO 8'h63
// ----------------------------------------
// reset values
// ----------------------------------------
`define FPVC_RST_ZERO 8'h00
`define FPVC_RST_PWRDLY 8'h81
`define FPVC_RST_BLINK 8'h83
// ----------------------------------------
// field positions
// ----------------------------------------
`define FPVC_VC_EN 0
`define FPVC_VC_AUTO 1
`define FPVC_VC_TXT_STRETCH 2
`define FPVC_VC_TXT_TALL 4
`define FPVC_VC_STRETCH_EN 5
`define FPVC_VC_PRIO 6
`define FPVC_INS_TOP_HI 6:5
`define FPVC_HEIGHT 3:0
`define FPVC_DLY_UP 7:4
`define FPVC_DLY_DN 3:0
`define FPVC_AC_MODE 7
`define FPVC_AC_COUNT 6:0
`define FPVC_BL_CURSOR 5:0
`define FPVC_BL_DUTY 7:6
`define FPVC_SEP_EN 0
`define FPVC_SEP_THR 4:1
`define FPVC_SEP_WRAP 5
`define FPVC_SEP_ENH 6
`define FPVC_POL 7
`define FPVC_SH_FG 3:0
`define FPVC_SH_BG 7:4
`define FPVC_MONO_THR 5:0
// ----------------------------------------
// timing: log2 of one power delay step in reference clocks, largest ac count that leaves the drive frozen, log2 of pixel blink half period in frames
// ----------------------------------------
`define FPVC_UP_STEP_LOG2 17
`define FPVC_DN_STEP_LOG2 20
`define FPVC_AC_MIN_COUNT 7'h02
`define FPVC_PIX_BLINK_LOG2 4
`endif

// [src/fpvc_panel_ext.v]
`timescale 1ns/1ps
`include "fpvc_consts.vh"

module fpvc_panel_ext #(
  parameter UP_STEP_LOG2 = `FPVC_UP_STEP_LOG2,
  parameter DN_STEP_LOG2 = `FPVC_DN_STEP_LOG2
) (
  // clock and reset (core_clk is the input reference clock)
  input wire core_clk,
  input wire rst,
  // indexed extension register port
  input wire io_index_we,
  input wire io_data_we,
  input wire [7:0] io_wdata,
  output reg [7:0] io_rdata_ff,
  // display timing
  input wire text_mode,
  input wire hsync_pulse,
  input wire vsync_pulse,
  input wire row_end_pulse,
  input wire double_scan_req,
  input wire panel_power_req,
  // colour path
  input wire color_display,
  input wire [3:0] fg_color,
  input wire [3:0] bg_color,
  input wire pixel_is_fg,
  input wire [5:0] lut_video,
  // vertical compensation
  output reg vertical_stretch_active_ff,
  output reg stretch_priority_select_ff,
  output reg use_top_border_ff,
  output reg [9:0] top_border_value_ff,
  output reg insert_line_ff,
  output reg double_scanning_ff,
  output reg line_replication_ff,
  // panel power and drive
  output reg panel_logic_supply_enable_ff,
  output reg panel_drive_oe_ff,
  output reg panel_bias_supply_enable_ff,
  output reg panel_ac_drive_toggle_ff,
  // blink and video
  output reg cursor_blink_on_ff,
  output reg char_blink_on_ff,
  output reg pixel_blink_on_ff,
  output reg [5:0] panel_video_ff,
  output reg mono_pixel_ff
);

  // ----------------------------------------
  // register file
  // ----------------------------------------
  reg [7:0] index_ff;
  reg [7:0] vcomp_ff, toplo_ff, insert_ff, repl_ff, pwrdly_ff;
  reg [7:0] acdrv_ff, blink_ff, sepctl_ff, shift_ff, mono_ff;
  wire [2:0] pwr_state;
  wire [7:0] status;

  always @(posedge core_clk) begin
    if (rst) begin
      index_ff <= `FPVC_RST_ZERO;
      vcomp_ff <= `FPVC_RST_ZERO;
      toplo_ff <= `FPVC_RST_ZERO;
      insert_ff <= `FPVC_RST_ZERO;
      repl_ff <= `FPVC_RST_ZERO;
      pwrdly_ff <= `FPVC_RST_PWRDLY;
      acdrv_ff <= `FPVC_RST_ZERO;
      blink_ff <= `FPVC_RST_BLINK;
      sepctl_ff <= `FPVC_RST_ZERO;
      shift_ff <= `FPVC_RST_ZERO;
      mono_ff <= `FPVC_RST_ZERO;
    end else begin
      if (io_index_we) begin
        index_ff <= io_wdata;
      end
      if (io_data_we) begin
        case (index_ff)
          `FPVC_IDX_VCOMP: vcomp_ff <= io_wdata & 8'h7F;
          `FPVC_IDX_TOPLO: toplo_ff <= io_wdata;
          `FPVC_IDX_INSERT: insert_ff <= io_wdata & 8'h6F;
          `FPVC_IDX_REPL: repl_ff <= io_wdata & 8'h0F;
          `FPVC_IDX_PWRDLY: pwrdly_ff <= io_wdata;
          `FPVC_IDX_ACDRV: acdrv_ff <= io_wdata;
          `FPVC_IDX_BLINK: blink_ff <= io_wdata;
          `FPVC_IDX_SEPCTL: sepctl_ff <= io_wdata;
          `FPVC_IDX_SHIFT: shift_ff <= io_wdata;
          `FPVC_IDX_MONO: mono_ff <= io_wdata & 8'hBF;
          default: begin
          end
        endcase
      end
    end
  end

  assign status = {panel_ac_drive_toggle_ff, cursor_blink_on_ff, char_blink_on_ff,
                   insert_line_ff, 1'b0, pwr_state};

  // read data follows the index one clock later
  always @(posedge core_clk) begin
    if (rst) begin
      io_rdata_ff <= `FPVC_RST_ZERO;
    end else begin
      case (index_ff)
        `FPVC_IDX_VCOMP: io_rdata_ff <= vcomp_ff;
        `FPVC_IDX_TOPLO: io_rdata_ff <= toplo_ff;
        `FPVC_IDX_INSERT: io_rdata_ff <= insert_ff;
        `FPVC_IDX_REPL: io_rdata_ff <= repl_ff;
        `FPVC_IDX_PWRDLY: io_rdata_ff <= pwrdly_ff;
        `FPVC_IDX_STATUS: io_rdata_ff <= status;
        `FPVC_IDX_ACDRV: io_rdata_ff <= acdrv_ff;
        `FPVC_IDX_BLINK: io_rdata_ff <= blink_ff;
        `FPVC_IDX_SEPCTL: io_rdata_ff <= sepctl_ff;
        `FPVC_IDX_SHIFT: io_rdata_ff <= shift_ff;
        `FPVC_IDX_MONO: io_rdata_ff <= mono_ff;
        default: io_rdata_ff <= `FPVC_RST_ZERO;
      endcase
    end
  end

  // ----------------------------------------
  // vertical compensation
  // ----------------------------------------
  wire comp_en = vcomp_ff[`FPVC_VC_EN];
  wire stretch_en = comp_en & vcomp_ff[`FPVC_VC_STRETCH_EN];
  wire insert_en = comp_en & text_mode & vcomp_ff[`FPVC_VC_TXT_STRETCH] &
                   ~vcomp_ff[`FPVC_VC_TXT_TALL];
  reg [4:0] ins_left_ff;
  reg [3:0] repl_cnt_ff;
  wire inserting = (ins_left_ff != 5'h00);

  always @(posedge core_clk) begin
    if (rst) begin
      vertical_stretch_active_ff <= 1'b0;
      stretch_priority_select_ff <= 1'b0;
      use_top_border_ff <= 1'b0;
      top_border_value_ff <= 10'h000;
      ins_left_ff <= 5'h00;
      insert_line_ff <= 1'b0;
      double_scanning_ff <= 1'b0;
      repl_cnt_ff <= 4'h0;
      line_replication_ff <= 1'b0;
    end else begin
      vertical_stretch_active_ff <= stretch_en;
      stretch_priority_select_ff <= stretch_en & vcomp_ff[`FPVC_VC_PRIO];
      use_top_border_ff <= comp_en & ~vcomp_ff[`FPVC_VC_AUTO];
      top_border_value_ff <= {insert_ff[`FPVC_INS_TOP_HI], toplo_ff};
      if (row_end_pulse && insert_en) begin
        ins_left_ff <= {1'b0, insert_ff[`FPVC_HEIGHT]} + 5'h01;
      end else if (hsync_pulse && inserting) begin
        ins_left_ff <= ins_left_ff - 5'h01;
      end
      insert_line_ff <= inserting;
      double_scanning_ff <= double_scan_req & ~inserting;
      line_replication_ff <= 1'b0;
      if (!stretch_en) begin
        repl_cnt_ff <= 4'h0;
      end else if (hsync_pulse && !inserting) begin
        // every output line except inserted ones counts, double scanned ones included
        if (repl_cnt_ff == repl_ff[`FPVC_HEIGHT]) begin
          repl_cnt_ff <= 4'h0;
          line_replication_ff <= 1'b1;
        end else begin
          repl_cnt_ff <= repl_cnt_ff + 4'h1;
        end
      end
    end
  end

  // ----------------------------------------
  // panel power sequencing
  // ----------------------------------------
  localparam PS_OFF = 3'h0;
  localparam PS_UP1 = 3'h1;
  localparam PS_UP2 = 3'h2;
  localparam PS_ON = 3'h3;
  localparam PS_DN1 = 3'h4;
  localparam PS_DN2 = 3'h5;
  reg [2:0] ps_ff;
  reg [24:0] dly_ff;
  wire [24:0] up_steps = {21'h000000, pwrdly_ff[`FPVC_DLY_UP]} + 25'h0000001;
  wire [24:0] dn_steps = {21'h000000, pwrdly_ff[`FPVC_DLY_DN]} + 25'h0000001;
  wire [24:0] up_dly = up_steps << UP_STEP_LOG2;
  wire [24:0] dn_dly = dn_steps << DN_STEP_LOG2;
  wire dly_done = (dly_ff == 25'h0000001);
  assign pwr_state = ps_ff;

  always @(posedge core_clk) begin
    if (rst) begin
      ps_ff <= PS_OFF;
      dly_ff <= 25'h0000000;
      panel_logic_supply_enable_ff <= 1'b0;
      panel_drive_oe_ff <= 1'b0;
      panel_bias_supply_enable_ff <= 1'b0;
    end else begin
      if (dly_ff != 25'h0000000) begin
        dly_ff <= dly_ff - 25'h0000001;
      end
      case (ps_ff)
        PS_OFF: begin
          if (panel_power_req) begin
            panel_logic_supply_enable_ff <= 1'b1;
            dly_ff <= up_dly;
            ps_ff <= PS_UP1;
          end
        end
        PS_UP1: begin
          if (dly_done) begin
            panel_drive_oe_ff <= 1'b1;
            dly_ff <= up_dly;
            ps_ff <= PS_UP2;
          end
        end
        PS_UP2: begin
          if (dly_done) begin
            panel_bias_supply_enable_ff <= 1'b1;
            ps_ff <= PS_ON;
          end
        end
        PS_ON: begin
          if (!panel_power_req) begin
            panel_bias_supply_enable_ff <= 1'b0;
            dly_ff <= dn_dly;
            ps_ff <= PS_DN1;
          end
        end
        PS_DN1: begin
          if (dly_done) begin
            panel_drive_oe_ff <= 1'b0;
            dly_ff <= dn_dly;
            ps_ff <= PS_DN2;
          end
        end
        PS_DN2: begin
          if (dly_done) begin
            panel_logic_supply_enable_ff <= 1'b0;
            ps_ff <= PS_OFF;
          end
        end
        default: begin
          ps_ff <= PS_OFF;
        end
      endcase
    end
  end

  // ----------------------------------------
  // ac drive toggle
  // ----------------------------------------
  reg [7:0] ac_cnt_ff;
  wire [7:0] ac_period = {1'b0, acdrv_ff[`FPVC_AC_COUNT]} + 8'h02;

  always @(posedge core_clk) begin
    if (rst) begin
      ac_cnt_ff <= 8'h00;
      panel_ac_drive_toggle_ff <= 1'b0;
    end else if (acdrv_ff[`FPVC_AC_MODE]) begin
      ac_cnt_ff <= 8'h00;
      if (vsync_pulse) begin
        panel_ac_drive_toggle_ff <= ~panel_ac_drive_toggle_ff;
      end
    end else if (acdrv_ff[`FPVC_AC_COUNT] > `FPVC_AC_MIN_COUNT) begin
      if (hsync_pulse) begin
        if (ac_cnt_ff >= ac_period - 8'h01) begin
          ac_cnt_ff <= 8'h00;
          panel_ac_drive_toggle_ff <= ~panel_ac_drive_toggle_ff;
        end else begin
          ac_cnt_ff <= ac_cnt_ff + 8'h01;
        end
      end
    end else begin
      // small counts leave the drive phase frozen
      ac_cnt_ff <= 8'h00;
    end
  end

  // ----------------------------------------
  // blink timing
  // ----------------------------------------
  reg [5:0] half_cnt_ff;
  reg [1:0] quarter_ff;
  reg [4:0] pix_cnt_ff;
  wire [1:0] duty = blink_ff[`FPVC_BL_DUTY];
  reg char_on;

  always @* begin
    case (duty)
      2'h0: char_on = ~quarter_ff[0];
      2'h1: char_on = (quarter_ff == 2'h0);
      2'h3: char_on = (quarter_ff != 2'h3);
      default: char_on = ~quarter_ff[1];
    endcase
  end

  always @(posedge core_clk) begin
    if (rst) begin
      half_cnt_ff <= 6'h00;
      quarter_ff <= 2'h0;
      pix_cnt_ff <= 5'h00;
      cursor_blink_on_ff <= 1'b1;
      char_blink_on_ff <= 1'b1;
      pixel_blink_on_ff <= 1'b1;
    end else begin
      if (vsync_pulse) begin
        pix_cnt_ff <= pix_cnt_ff + 5'h01;
        if (half_cnt_ff >= blink_ff[`FPVC_BL_CURSOR]) begin
          half_cnt_ff <= 6'h00;
          quarter_ff <= quarter_ff + 2'h1;
        end else begin
          half_cnt_ff <= half_cnt_ff + 6'h01;
        end
      end
      cursor_blink_on_ff <= ~quarter_ff[0];
      char_blink_on_ff <= char_on;
      pixel_blink_on_ff <= ~pix_cnt_ff[`FPVC_PIX_BLINK_LOG2];
    end
  end

  // ----------------------------------------
  // text colour separation and video out
  // ----------------------------------------
  // shift one colour away from the other, clamped or wrapped
  function [3:0] fpvc_shift;
    input [3:0] own;
    input [3:0] other;
    input [3:0] amount;
    input wrap;
    reg [4:0] sum;
    begin
      if (own > other) begin
        sum = {1'b0, own} + {1'b0, amount};
        fpvc_shift = (sum[4] && !wrap) ? 4'hF : sum[3:0];
      end else begin
        sum = {1'b0, own} - {1'b0, amount};
        fpvc_shift = (sum[4] && !wrap) ? 4'h0 : sum[3:0];
      end
    end
  endfunction

  // attribute 07h and 0Fh trade places under enhancement
  function [3:0] fpvc_enh;
    input [3:0] c;
    input en;
    begin
      if (en && c == 4'h7) begin
        fpvc_enh = 4'hF;
      end else if (en && c == 4'hF) begin
        fpvc_enh = 4'h7;
      end else begin
        fpvc_enh = c;
      end
    end
  endfunction

  wire sep_on = text_mode & sepctl_ff[`FPVC_SEP_EN];
  wire wrap = sepctl_ff[`FPVC_SEP_WRAP];
  wire [3:0] fg_e = fpvc_enh(fg_color, text_mode & sepctl_ff[`FPVC_SEP_ENH]);
  wire [3:0] bg_e = fpvc_enh(bg_color, text_mode & sepctl_ff[`FPVC_SEP_ENH]);
  wire [3:0] diff = (fg_e > bg_e) ? (fg_e - bg_e) : (bg_e - fg_e);
  wire close = (diff < sepctl_ff[`FPVC_SEP_THR]) && (diff != 4'h0);
  wire [3:0] fg_s = close ? fpvc_shift(fg_e, bg_e, shift_ff[`FPVC_SH_FG], wrap) : fg_e;
  wire [3:0] bg_s = close ? fpvc_shift(bg_e, fg_e, shift_ff[`FPVC_SH_BG], wrap) : bg_e;
  wire [3:0] pix4 = (pixel_is_fg && !insert_line_ff) ? fg_s : bg_s;
  wire [5:0] pix6 = {pix4[3], pix4[3],
                     color_display ? (|pix4) : pix4[3], pix4[2:0]};
  wire [5:0] video = sep_on ? pix6 : lut_video;
  wire invert = text_mode ? sepctl_ff[`FPVC_POL] : mono_ff[`FPVC_POL];

  always @(posedge core_clk) begin
    if (rst) begin
      panel_video_ff <= 6'h00;
      mono_pixel_ff <= 1'b0;
    end else begin
      panel_video_ff <= video ^ {6{invert}};
      mono_pixel_ff <= (video >= mono_ff[`FPVC_MONO_THR]) ^ invert;
    end
  end

endmodule

// [testbench/fpvc_checker_properties.sv]
`timescale 1ns/1ps
module fpvc_checker (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // timing inputs
  input wire hsync_pulse,
  input wire vsync_pulse,
  input wire panel_power_req,
  // watched outputs
  input wire vertical_stretch_active_ff,
  input wire stretch_priority_select_ff,
  input wire insert_line_ff,
  input wire double_scanning_ff,
  input wire panel_logic_supply_enable_ff,
  input wire panel_drive_oe_ff,
  input wire panel_bias_supply_enable_ff,
  input wire panel_ac_drive_toggle_ff,
  input wire cursor_blink_on_ff,
  input wire pixel_blink_on_ff
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire vdd = panel_logic_supply_enable_ff;
  wire oe = panel_drive_oe_ff;
  wire bias = panel_bias_supply_enable_ff;
  // ----------------------------------------
  // properties
  // ----------------------------------------
  a_prio_needs_stretch: assert property (
    stretch_priority_select_ff |-> vertical_stretch_active_ff) else $error("priority alone");
  a_insert_no_double: assert property (
    insert_line_ff |-> !double_scanning_ff) else $error("inserted line double scanned");
  a_bias_needs_drive: assert property (
    bias |-> oe) else $error("bias without drive");
  a_drive_needs_logic: assert property (
    oe |-> vdd) else $error("drive without logic supply");
  a_up_starts_logic: assert property (
    panel_power_req && !vdd && !oe && !bias |-> ##[1:2] vdd) else $error("power up stuck");
  a_logic_leads_drive: assert property (
    $rose(vdd) |-> !oe [*3]) else $error("drive too early");
  a_down_bias_first: assert property (
    !panel_power_req && vdd && oe && bias |-> ##[1:2] !bias) else $error("bias not dropped");
  a_ac_on_sync: assert property (
    $changed(panel_ac_drive_toggle_ff) |-> $past(hsync_pulse) || $past(vsync_pulse)
      || $past(hsync_pulse, 2) || $past(vsync_pulse, 2)) else $error("ac toggle off sync");
  a_cursor_on_vsync: assert property (
    $changed(cursor_blink_on_ff) |-> $past(vsync_pulse) || $past(vsync_pulse, 2))
    else $error("cursor blink off vsync");
  a_pixel_on_vsync: assert property (
    $changed(pixel_blink_on_ff) |-> $past(vsync_pulse) || $past(vsync_pulse, 2))
    else $error("pixel blink off vsync");
  c_bias_up: cover property ($rose(bias));
  c_logic_down: cover property ($fell(vdd));
  c_insert_done: cover property (insert_line_ff ##1 !insert_line_ff);
endmodule

// [testbench/fpvc_panel_ext_bench.sv]
`timescale 1ns/1ps
module fpvc_panel_ext_bench;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  reg core_clk, rst, io_index_we, io_data_we, text_mode, hsync_pulse, vsync_pulse;
  reg row_end_pulse, double_scan_req, panel_power_req, color_display, pixel_is_fg, rep_seen;
  reg [7:0] io_wdata;
  reg [3:0] fg_color, bg_color;
  reg [5:0] lut_video;
  wire [7:0] io_rdata_ff;
  wire [9:0] top_border_value_ff;
  wire [5:0] panel_video_ff;
  wire vertical_stretch_active_ff, stretch_priority_select_ff, use_top_border_ff;
  wire insert_line_ff, double_scanning_ff, line_replication_ff, panel_logic_supply_enable_ff;
  wire panel_drive_oe_ff, panel_bias_supply_enable_ff, panel_ac_drive_toggle_ff;
  wire cursor_blink_on_ff, char_blink_on_ff, pixel_blink_on_ff, mono_pixel_ff, fault_ff;
  wire [5:0] seen_video;
  wire [2:0] pwr = {panel_bias_supply_enable_ff, panel_drive_oe_ff, panel_logic_supply_enable_ff};
  wire [4:0] obs = {rep_seen, pixel_blink_on_ff, char_blink_on_ff, cursor_blink_on_ff,
    panel_ac_drive_toggle_ff};
  integer bad_count = 0;
  integer comparisons = 0;
  // short power steps keep the run brief
  fpvc_panel_ext #(.UP_STEP_LOG2(2), .DN_STEP_LOG2(2)) dut (.core_clk, .rst, .io_index_we,
    .io_data_we, .io_wdata, .io_rdata_ff, .text_mode, .hsync_pulse, .vsync_pulse,
    .row_end_pulse, .double_scan_req, .panel_power_req, .color_display, .fg_color, .bg_color,
    .pixel_is_fg, .lut_video, .vertical_stretch_active_ff, .stretch_priority_select_ff,
    .use_top_border_ff, .top_border_value_ff, .insert_line_ff, .double_scanning_ff,
    .line_replication_ff, .panel_logic_supply_enable_ff, .panel_drive_oe_ff,
    .panel_bias_supply_enable_ff, .panel_ac_drive_toggle_ff, .cursor_blink_on_ff,
    .char_blink_on_ff, .pixel_blink_on_ff, .panel_video_ff, .mono_pixel_ff);
  fpvc_panel_model panel (.core_clk, .vdd_en(panel_logic_supply_enable_ff),
    .drive_oe(panel_drive_oe_ff), .bias_en(panel_bias_supply_enable_ff),
    .video(panel_video_ff), .seen_video_ff(seen_video), .fault_ff);
  initial begin
    core_clk = 0;
    forever #25 core_clk = ~core_clk;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task tout;
    bad_count = bad_count + 1;
    end_of_test;
  endtask
  task tick(input integer n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task chk(input [15:0] seen, input [15:0] exp, input [79:0] what);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("MISMATCH %0s exp %0h seen %0h", what, exp, seen);
    end
  endtask
  task wr(input [7:0] i, input [7:0] d);
    io_index_we = 1;
    io_wdata = i;
    tick(1);
    io_index_we = 0;
    io_data_we = 1;
    io_wdata = d;
    tick(1);
    io_data_we = 0;
    tick(2);
  endtask
  task rd(input [7:0] i, input [7:0] e);
    io_index_we = 1;
    io_wdata = i;
    tick(1);
    io_index_we = 0;
    tick(1);
    chk(io_rdata_ff, e, "rdata");
  endtask
  // one sync event, then watch four cycles for a replication pulse
  task ev(input h, input v, input r);
    integer k;
    {hsync_pulse, vsync_pulse, row_end_pulse} = {h, v, r};
    rep_seen = 0;
    for (k = 0; k < 4; k = k + 1) begin
      tick(1);
      {hsync_pulse, vsync_pulse, row_end_pulse} = 3'h0;
      if (line_replication_ff === 1'b1) rep_seen = 1;
    end
  endtask
  function hit(input integer s, input hv);
    hit = (s == 4) ? (obs[4] === 1'b1) : (obs[s] !== hv);
  endfunction
  // events from one change of obs[s] to the next; hv is the level held meanwhile
  task gap(input integer s, input h, output integer n, output hv);
    integer k;
    hv = obs[s];
    for (k = 0; k < 80 && !hit(s, hv); k = k + 1) ev(h, !h, 0);
    if (k >= 80) tout;
    hv = obs[s];
    n = 0;
    do begin
      ev(h, !h, 0);
      n = n + 1;
    end while (!hit(s, hv) && n < 80);
    if (n >= 80) tout;
  endtask
  task pw(input integer s, input v, output integer n);
    n = 0;
    while (pwr[s] !== v && n < 300) begin
      tick(1);
      n = n + 1;
    end
    if (n >= 300) tout;
  endtask
  task vid(input tm, input cd, input [3:0] f, input [3:0] b, input [5:0] lut, input [6:0] e);
    {text_mode, color_display, fg_color, bg_color, lut_video} = {tm, cd, f, b, lut};
    tick(2);
    chk(tm ? panel_video_ff : {mono_pixel_ff, panel_video_ff}, tm ? e[5:0] : e, "video");
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_regs;
    rd(8'h5B, 8'h81);
    rd(8'h60, 8'h83);
    wr(8'h40, 8'h5A);
    rd(8'h40, 8'h00);
    wr(8'h59, 8'hFF);
    rd(8'h59, 8'h6F);
    wr(8'h58, 8'hA5);
    wr(8'h57, 8'h01);
    chk(top_border_value_ff, 10'h3A5, "border");
    chk(use_top_border_ff, 1'b1, "usetop");
    wr(8'h57, 8'h03);
    chk(use_top_border_ff, 1'b0, "usetop");
    wr(8'h57, 8'h60);
    chk(vertical_stretch_active_ff, 1'b0, "stretch");
    wr(8'h57, 8'h21);
    chk({vertical_stretch_active_ff, stretch_priority_select_ff}, 2'h2, "stretch");
    wr(8'h57, 8'h61);
    chk({vertical_stretch_active_ff, stretch_priority_select_ff}, 2'h3, "stretch");
    $display("done regs");
  endtask
  task t_power;
    integer n;
    wr(8'h5B, 8'h10);
    lut_video = 6'h15;
    panel_power_req = 1;
    pw(0, 1'b1, n);
    chk(pwr, 3'h1, "pwrup");
    // request withdrawn mid-sequence: power up must still finish first
    panel_power_req = 0;
    pw(1, 1'b1, n);
    chk(n, 8, "upstep");
    pw(2, 1'b1, n);
    chk(n, 8, "upstep");
    chk(seen_video, 6'h15, "panelvid");
    pw(2, 1'b0, n);
    chk(pwr, 3'h3, "pwrdn");
    pw(1, 1'b0, n);
    chk(n, 4, "dnstep");
    pw(0, 1'b0, n);
    chk(n, 4, "dnstep");
    chk(fault_ff, 1'b0, "panel");
    $display("done power");
  endtask
  task t_ac;
    integer n, k;
    reg hv, a;
    wr(8'h5E, 8'h03);
    gap(0, 1, n, hv);
    chk(n, 5, "acgap");
    wr(8'h5E, 8'h80);
    gap(0, 0, n, hv);
    chk(n, 1, "acframe");
    for (k = 0; k < 2; k = k + 1) begin
      a = panel_ac_drive_toggle_ff;
      repeat (8) ev(1, 0, 0);
      chk(panel_ac_drive_toggle_ff, a, "acfrozen");
      wr(8'h5E, 8'h02);
    end
    $display("done ac");
  endtask
  task t_blink;
    integer n, d, on;
    reg hv;
    text_mode = 0;
    gap(1, 0, n, hv);
    chk(n, 4, "cursor");
    wr(8'h60, 8'h01);
    gap(1, 0, n, hv);
    chk(n, 2, "cursor");
    gap(3, 0, n, hv);
    chk(n, 16, "pixel");
    text_mode = 1;
    for (d = 0; d < 4; d = d + 1) begin
      wr(8'h60, {d[1:0], 6'h01});
      gap(2, 0, n, hv);
      gap(2, 0, n, hv);
      on = (d == 3) ? 6 : (d == 2) ? 4 : 2;
      chk(n, hv ? on : ((d == 0) ? 4 : 8) - on, "charblink");
    end
    $display("done blink");
  endtask
  task t_lines;
    integer n, k;
    reg hv;
    text_mode = 1;
    double_scan_req = 1;
    wr(8'h57, 8'h05);
    wr(8'h59, 8'h02);
    ev(0, 0, 1);
    n = 0;
    for (k = 0; k < 6; k = k + 1) begin
      n = n + (insert_line_ff === 1'b1);
      chk(double_scanning_ff, k >= 3, "dscan");
      ev(1, 0, 0);
    end
    chk(n, 3, "inserted");
    chk(double_scanning_ff, 1'b1, "dscan");
    text_mode = 0;
    wr(8'h57, 8'h21);
    wr(8'h5A, 8'h03);
    gap(4, 1, n, hv);
    chk(n, 4, "replicate");
    $display("done lines");
  endtask
  task t_video;
    pixel_is_fg = 1;
    wr(8'h61, 8'h01);
    vid(1, 0, 4'hA, 4'h0, 6'h00, 7'h3A);
    vid(1, 0, 4'h5, 4'h0, 6'h00, 7'h05);
    vid(1, 1, 4'h5, 4'h0, 6'h00, 7'h0D);
    wr(8'h62, 8'h32);
    wr(8'h61, 8'h09);
    vid(1, 0, 4'h6, 4'h5, 6'h00, 7'h38);
    vid(1, 0, 4'h6, 4'h6, 6'h00, 7'h06);
    vid(1, 0, 4'hE, 4'hD, 6'h00, 7'h3F);
    pixel_is_fg = 0;
    vid(1, 0, 4'h6, 4'h5, 6'h00, 7'h02);
    vid(1, 0, 4'h2, 4'h0, 6'h00, 7'h00);
    wr(8'h61, 8'h29);
    vid(1, 0, 4'h2, 4'h0, 6'h00, 7'h3D);
    pixel_is_fg = 1;
    wr(8'h61, 8'h41);
    vid(1, 0, 4'h7, 4'h0, 6'h00, 7'h3F);
    wr(8'h61, 8'h81);
    vid(1, 0, 4'hA, 4'h0, 6'h00, 7'h05);
    wr(8'h63, 8'h20);
    vid(0, 0, 4'h0, 4'h0, 6'h1F, 7'h1F);
    vid(0, 0, 4'h0, 4'h0, 6'h20, 7'h60);
    wr(8'h63, 8'hA0);
    vid(0, 0, 4'h0, 4'h0, 6'h20, 7'h1F);
    $display("done video");
  endtask
  initial begin
    rst = 1;
    {io_index_we, io_data_we, text_mode, hsync_pulse, vsync_pulse, row_end_pulse} = 6'h00;
    {double_scan_req, panel_power_req, color_display, pixel_is_fg, rep_seen} = 5'h00;
    {io_wdata, fg_color, bg_color, lut_video} = 22'h000000;
    repeat (16) @(posedge core_clk);
    #1;
    rst = 0;
    tick(1);
    t_regs;
    t_power;
    t_ac;
    t_blink;
    t_lines;
    t_video;
    end_of_test;
  end
endmodule

bind fpvc_panel_ext fpvc_checker u_chk (.core_clk, .rst, .hsync_pulse, .vsync_pulse,
  .panel_power_req, .vertical_stretch_active_ff, .stretch_priority_select_ff, .insert_line_ff,
  .double_scanning_ff, .panel_logic_supply_enable_ff, .panel_drive_oe_ff,
  .panel_bias_supply_enable_ff, .panel_ac_drive_toggle_ff, .cursor_blink_on_ff,
  .pixel_blink_on_ff);

// [testbench/fpvc_panel_model.sv]
`timescale 1ns/1ps
module fpvc_panel_model (
  // supplies and drive from the controller
  input wire core_clk,
  input wire vdd_en,
  input wire drive_oe,
  input wire bias_en,
  input wire [5:0] video,
  // panel view
  output reg [5:0] seen_video_ff = 6'h00,
  output reg fault_ff = 1'b0
);
  // floating data lines show a changing pattern so stale values never look valid
  always @(posedge core_clk) begin
    if (drive_oe)
      seen_video_ff <= video;
    else
      seen_video_ff <= ~seen_video_ff;
    if ((bias_en || drive_oe) && !vdd_en)
      fault_ff <= 1'b1;
  end
endmodule
